// *** rtl/slsld_top.sv ***
// Segment LCD driver: serial shift, strobe latch, common and segment drive.
// Assumes host pins are asynchronous and slow against the 40 MHz clock.
// Limitation: each serial clock level must last three clk cycles.
// rst_n stands in for power-up; the block has no other reset.
//
// Notes on behaviour
// RULE1: 120-stage shift register shifts in data on each serial clock rise.
// RULE2: While strobe is high, latch copies the whole shift register.
// RULE3: Host sends segment 60 bit first, segment 1 bit last.
// RULE4: Selected common toggles high/low with the internal phase reference.
// RULE5: Non-selected common holds the middle level.
// RULE6: Half-duty, first common selected: segments show latch bits 1..60.
// RULE7: Half-duty, second common selected: segments show latch bits 61..120.
// RULE8: Bit one gives inverse of common level; zero gives same level.
// RULE9: Host holds test inputs low after power-up until first latch.
// RULE10: Static mode: segment n follows lower half bit n every phase.
// RULE11: Static mode: upper latch half is ignored.
// RULE12: Latch holds its value while strobe is low.
// RULE13: Last shift stages appear on the cascade serial outputs.
`timescale 1ns/100ps
`default_nettype none
module slsld_top #(
  parameter logic [16:0] PHASE_MAX = slsld_pkg::PHASE_CNT_MAX
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic serial_data,
  input wire logic serial_clk,
  input wire logic latch_strobe,
  input wire logic half_duty,
  input wire logic all_on_test,
  input wire logic all_off_test,
  output logic [59:0] segment_output_n,
  output slsld_pkg::slsld_com_t com_one,
  output slsld_pkg::slsld_com_t com_two,
  output logic cascade_out_one,
  output logic cascade_out_two,
  output logic phase_ref
);
  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [5:0] pin_raw;
  logic [5:0] pin_s;
  assign pin_raw = {all_off_test, all_on_test, half_duty, latch_strobe,
                    serial_clk, serial_data};
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_sync
      slsld_sync u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .d(pin_raw[gi]),
        .q(pin_s[gi])
      );
    end
  endgenerate
  // Mode and test pins share the two-cycle latency of the link pins
  logic sd_s;
  logic sck_s;
  logic stb_s;
  logic duty_s;
  logic on_s;
  logic off_s;
  assign {off_s, on_s, duty_s, stb_s, sck_s, sd_s} = pin_s;

  // ****************************************
  // Shift register and latch
  // ****************************************
  // New bits enter stage 0; stage k holds latch bit k+1 after a load
  logic [119:0] shift_r;
  logic [119:0] shift_nxt;
  logic [119:0] latch_r;
  logic [119:0] latch_nxt;
  logic sck_d_r;
  logic sck_d_nxt;
  logic sck_rise;
  assign sck_rise = sck_s & ~sck_d_r;
  always_comb begin
    sck_d_nxt = sck_s;
    shift_nxt = shift_r;
    latch_nxt = latch_r;
    if (sck_rise) begin
      shift_nxt = {shift_r[slsld_pkg::STAGES-2:0], sd_s}; // RULE1 RULE3
    end
    // Strobe is a level: shifting under a high strobe shows through
    if (stb_s) begin
      latch_nxt = shift_r; // RULE2
    end // RULE12
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_r <= slsld_pkg::LATCH_RST;
      latch_r <= slsld_pkg::LATCH_RST;
      sck_d_r <= 1'b0;
    end else begin
      shift_r <= shift_nxt;
      latch_r <= latch_nxt;
      sck_d_r <= sck_d_nxt;
    end
  end
  // Ends of both halves; a static-mode neighbour chains off stage 59
  assign cascade_out_one = shift_r[slsld_pkg::STAGES-1]; // RULE13
  assign cascade_out_two = shift_r[slsld_pkg::SEGS-1]; // RULE13

  // ****************************************
  // Common phase generator
  // ****************************************
  // Quarter-frame length is a parameter so a bench can shorten it
  logic [16:0] cnt_r;
  logic [16:0] cnt_nxt;
  slsld_pkg::slsld_phase_t ph_r;
  slsld_pkg::slsld_phase_t ph_nxt;
  logic phase_step;
  // One-cycle enable at the end of each quarter frame
  assign phase_step = (cnt_r == PHASE_MAX);
  // Fixed four-step order; no external common sync is supported
  function automatic slsld_pkg::slsld_phase_t next_phase(
    input slsld_pkg::slsld_phase_t ph
  );
    unique case (ph)
      slsld_pkg::SLSLD_A_HI: next_phase = slsld_pkg::SLSLD_A_LO;
      slsld_pkg::SLSLD_A_LO: next_phase = slsld_pkg::SLSLD_B_HI;
      slsld_pkg::SLSLD_B_HI: next_phase = slsld_pkg::SLSLD_B_LO;
      slsld_pkg::SLSLD_B_LO: next_phase = slsld_pkg::SLSLD_A_HI;
    endcase
  endfunction
  always_comb begin
    cnt_nxt = cnt_r + 17'h1;
    ph_nxt = ph_r;
    if (phase_step) begin
      cnt_nxt = 17'h0;
      ph_nxt = next_phase(ph_r); // RULE4
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 17'h0;
      ph_r <= slsld_pkg::SLSLD_A_HI;
    end else begin
      cnt_r <= cnt_nxt;
      ph_r <= ph_nxt;
    end
  end

  // ****************************************
  // Common and segment drive
  // ****************************************
  // True in the two high-level phases
  function automatic logic phase_high(input slsld_pkg::slsld_phase_t ph);
    phase_high = (ph == slsld_pkg::SLSLD_A_HI) ||
                 (ph == slsld_pkg::SLSLD_B_HI);
  endfunction
  // True in the two phases that belong to the second common
  function automatic logic phase_second(input slsld_pkg::slsld_phase_t ph);
    phase_second = (ph == slsld_pkg::SLSLD_B_HI) ||
                   (ph == slsld_pkg::SLSLD_B_LO);
  endfunction
  logic lvl;
  logic sel_two;
  // Decoded from the registered phase so every pin steps together
  assign lvl = phase_high(ph_r);
  // Static mode keeps both commons on the same toggling level
  assign sel_two = duty_s & phase_second(ph_r);

  // ****************************************
  // Common drive
  // ****************************************
  slsld_pkg::slsld_com_t c1_nxt;
  slsld_pkg::slsld_com_t c2_nxt;
  slsld_pkg::slsld_com_t c1_r;
  slsld_pkg::slsld_com_t c2_r;
  logic pref_r;
  logic pref_nxt;
  always_comb begin
    pref_nxt = lvl;
    c1_nxt = '{mid: 1'b0, lvl: lvl}; // RULE4
    c2_nxt = '{mid: 1'b0, lvl: lvl}; // RULE4
    if (duty_s) begin
      if (sel_two) begin
        c1_nxt = '{mid: 1'b1, lvl: 1'b0}; // RULE5
      end else begin
        c2_nxt = '{mid: 1'b1, lvl: 1'b0}; // RULE5
      end
    end
  end
  // Reset parks every pin low: no drive before the first frame
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      c1_r <= '{mid: 1'b0, lvl: 1'b0};
      c2_r <= '{mid: 1'b0, lvl: 1'b0};
      pref_r <= 1'b0;
    end else begin
      c1_r <= c1_nxt;
      c2_r <= c2_nxt;
      pref_r <= pref_nxt;
    end
  end
  assign com_one = c1_r;
  assign com_two = c2_r;
  assign phase_ref = pref_r;

  // ****************************************
  // Segment drive
  // ****************************************
  logic [59:0] seg_nxt;
  logic [59:0] seg_r;
  always_comb begin
    // Upper half only reachable in half-duty phase B
    if (sel_two) begin
      seg_nxt = latch_r[119:60] ^ {60{lvl}}; // RULE7 RULE8 RULE11
    end else begin
      seg_nxt = latch_r[59:0] ^ {60{lvl}}; // RULE6 RULE8 RULE10
    end
    // Blank wins over all-on; both force level relative to common
    if (off_s) begin
      seg_nxt = {60{lvl}};
    end else if (on_s) begin
      seg_nxt = {60{~lvl}};
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      seg_r <= 60'h0;
    end else begin
      seg_r <= seg_nxt;
    end
  end
  assign segment_output_n = seg_r;
endmodule
`default_nettype wire

// *** rtl/slsld_pkg.sv ***
// Package for the segment LCD shift/latch driver.
// Assumes one 40 MHz clock; host pins sampled by the block.
package slsld_pkg;
  localparam int STAGES = 120;
  localparam int SEGS = 60;
  localparam logic [119:0] LATCH_RST = 120'h0;
  // Common phase reference divider, default gives about 100 Hz frame
  localparam int CLK_HZ = 40000000;
  localparam int COM_HZ = 100;
  localparam int PHASE_CYC = CLK_HZ / (COM_HZ * 4);
  localparam logic [16:0] PHASE_CNT_MAX = 17'(PHASE_CYC - 1);
  localparam logic [1:0] SYNC_RST = 2'h0;

  // Common drive level per pin: level high/low, or middle
  typedef struct packed {
    logic mid;
    logic lvl;
  } slsld_com_t;

  typedef enum logic [1:0] {
    SLSLD_A_HI = 2'b00,
    SLSLD_A_LO = 2'b01,
    SLSLD_B_HI = 2'b10,
    SLSLD_B_LO = 2'b11
  } slsld_phase_t;
endpackage

// *** rtl/slsld_sync.sv ***
// Two flip-flop synchroniser for one pin.
// Assumes the pin is asynchronous to clk.
`timescale 1ns/100ps
`default_nettype none
module slsld_sync (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic d,
  output logic q
);
  logic [1:0] s_r;
  logic [1:0] s_nxt;
  always_comb begin
    s_nxt = {s_r[0], d};
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= slsld_pkg::SYNC_RST;
    end else begin
      s_r <= s_nxt;
    end
  end
  assign q = s_r[1];
endmodule
`default_nettype wire

// *** dv/slsld_properties.sv ***
// Port checker for slsld_top.
// Assumes binding to slsld_top; one clock domain.
`timescale 1ns/100ps
`default_nettype none
module slsld_properties (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic serial_clk,
  input wire logic latch_strobe,
  input wire logic half_duty,
  input wire logic all_on_test,
  input wire logic all_off_test,
  input wire logic [59:0] segment_output_n,
  input wire slsld_pkg::slsld_com_t com_one,
  input wire slsld_pkg::slsld_com_t com_two,
  input wire logic cascade_out_one,
  input wire logic cascade_out_two,
  input wire logic phase_ref
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Eight quiet cycles cover the sync latency
  sequence s_quiet;
    (!latch_strobe && $stable(all_on_test) && $stable(all_off_test) &&
     $stable(com_one) && $stable(com_two))[*8];
  endsequence
  AST_HOLD: assert property (s_quiet |-> $stable(segment_output_n))
    else $error("segments moved with strobe low");
  AST_CASC: assert property (!serial_clk[*8] |-> $stable(cascade_out_one))
    else $error("shift without serial clock rise");
  AST_MID: assert property (!(com_one.mid && com_two.mid))
    else $error("both commons at middle");
  AST_STAT: assert property (!half_duty[*8] |-> !com_one.mid && com_one == com_two)
    else $error("static commons differ");
  AST_HALF: assert property (half_duty[*8] |-> com_one.mid != com_two.mid)
    else $error("half duty selection wrong");
  AST_REF: assert property (($stable(phase_ref) && !com_one.mid)[*4] |-> com_one.lvl == phase_ref)
    else $error("common level off reference");
  AST_OFF: assert property ((all_off_test && !com_one.mid && $stable(com_one))[*5] |-> segment_output_n == {60{com_one.lvl}})
    else $error("all off wrong");
  AST_ON: assert property ((all_on_test && !all_off_test && !com_one.mid && $stable(com_one))[*5] |-> segment_output_n == {60{!com_one.lvl}})
    else $error("all on wrong");
endmodule
bind slsld_top slsld_properties i_slsld_properties (.clk(clk), .rst_n(rst_n),
  .serial_clk(serial_clk), .latch_strobe(latch_strobe), .half_duty(half_duty),
  .all_on_test(all_on_test), .all_off_test(all_off_test),
  .segment_output_n(segment_output_n), .com_one(com_one), .com_two(com_two),
  .cascade_out_one(cascade_out_one), .cascade_out_two(cascade_out_two),
  .phase_ref(phase_ref));
`default_nettype wire

// *** dv/slsld_host.sv ***
// Host model: serial data, serial clock, strobe.
// Assumes the bench clock; drives at falling edges.
`timescale 1ns/100ps
`default_nettype none
module slsld_host (
  input wire logic clk,
  output logic serial_data,
  output logic serial_clk,
  output logic latch_strobe
);
  initial begin
    serial_data = 1'b0;
    serial_clk = 1'b0;
    latch_strobe = 1'b0;
  end
  // 200 ns clock, low between words; stale data inverted
  task automatic send(input logic [119:0] w);
    for (int i = 119; i >= 0; i--) begin
      @(negedge clk) serial_data = w[i];
      repeat (3) @(negedge clk);
      serial_clk = 1'b1;
      repeat (4) @(negedge clk);
      serial_clk = 1'b0;
      serial_data = !w[i];
    end
  endtask
  task automatic pulse();
    @(negedge clk) latch_strobe = 1'b1;
    repeat (8) @(negedge clk);
    latch_strobe = 1'b0;
    repeat (6) @(negedge clk);
  endtask
endmodule
`default_nettype wire

// *** dv/slsld_top_test.sv ***
// Bench for slsld_top with host model.
// Assumes 40 MHz clock; quarter frame shortened to 4096 cycles.
`timescale 1ns/100ps
`default_nettype none
module slsld_top_test;
  logic clk, rst_n, half_duty, all_on_test, all_off_test, serial_data;
  logic serial_clk, latch_strobe, cascade_out_one, cascade_out_two, phase_ref;
  logic [59:0] segment_output_n;
  slsld_pkg::slsld_com_t com_one, com_two;
  int fail_count, checked;
  localparam logic [119:0] W1 = {60'h0f0f0f0f0f0f0f0, 60'h123456789abcdef};
  localparam logic [119:0] W2 = {60'haaaaaaaaaaaaaaa, 60'h9876543210fedcb};
  always #12.5 clk = !clk;
  slsld_host i_slsld_host (.clk(clk), .serial_data(serial_data),
    .serial_clk(serial_clk), .latch_strobe(latch_strobe));
  slsld_top #(.PHASE_MAX(17'h00fff)) i_slsld_top (.clk(clk), .rst_n(rst_n),
    .serial_data(serial_data),
    .serial_clk(serial_clk), .latch_strobe(latch_strobe),
    .half_duty(half_duty), .all_on_test(all_on_test),
    .all_off_test(all_off_test), .segment_output_n(segment_output_n),
    .com_one(com_one), .com_two(com_two), .cascade_out_one(cascade_out_one),
    .cascade_out_two(cascade_out_two), .phase_ref(phase_ref));
  task automatic chk(input logic [59:0] seen, input logic [59:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("mismatches %0d checks %0d", fail_count, checked);
    if (fail_count == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic t_static();
    i_slsld_host.send(W1);
    i_slsld_host.pulse();
    chk(segment_output_n, ~W1[59:0]);
    chk(60'(com_one), 60'h1);
    chk(60'({cascade_out_one, cascade_out_two}), 60'h0);
  endtask
  task automatic t_hold();
    i_slsld_host.send(W2);
    chk(segment_output_n, ~W1[59:0]);
    chk(60'({cascade_out_one, cascade_out_two}), 60'h3);
  endtask
  task automatic t_test();
    all_on_test = 1'b1;
    repeat (8) @(negedge clk);
    chk(segment_output_n, '0);
    all_off_test = 1'b1;
    repeat (8) @(negedge clk);
    chk(segment_output_n, '1);
    all_on_test = 1'b0;
    all_off_test = 1'b0;
    repeat (8) @(negedge clk);
  endtask
  task automatic t_half();
    half_duty = 1'b1;
    i_slsld_host.pulse();
    chk(segment_output_n, ~W2[59:0]);
    chk(60'({com_one, com_two}), 60'h6);
  endtask
  // Walks the commons through A_LO, B_HI and B_LO of one frame
  task automatic t_phase();
    for (int i = 0; i < 10000 && com_one.lvl !== 1'b0; i++) @(negedge clk);
    repeat (3) @(negedge clk);
    chk(segment_output_n, W2[59:0]);
    chk(60'({phase_ref, com_one, com_two}), 60'h2);
    for (int i = 0; i < 10000 && com_two.mid !== 1'b0; i++) @(negedge clk);
    repeat (3) @(negedge clk);
    chk(segment_output_n, ~W2[119:60]);
    chk(60'({phase_ref, com_one, com_two}), 60'h19);
    for (int i = 0; i < 10000 && com_two.lvl !== 1'b0; i++) @(negedge clk);
    repeat (3) @(negedge clk);
    chk(segment_output_n, W2[119:60]);
    chk(60'({phase_ref, com_one, com_two}), 60'h8);
  endtask
  initial begin
    #1000000;
    fail_count++;
    end_of_test();
  end
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    half_duty = 1'b0;
    all_on_test = 1'b0;
    all_off_test = 1'b0;
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    t_static();
    t_hold();
    t_test();
    t_half();
    t_phase();
    end_of_test();
  end
endmodule
`default_nettype wire
